/* File: cvsdc_pkg.sv */
// Shared constants for the slope control logic of the delta modulation codec.
// Assumes a single 10 MHz system clock from which the bit clock enable is derived.
package cvsdc_pkg;

  localparam int unsigned CLK_HZ          = 10_000_000;
  // Bit clock rate in Hz; voice use needs at least 8 kHz, 16 to 32 kHz is customary.
  localparam int unsigned BIT_RATE_MIN_HZ = 8_000;
  localparam int unsigned BIT_RATE_HZ     = 16_000;
  // Longest whole number of system cycles per bit that still meets the rate.
  localparam int unsigned BIT_DIV_CYC     = CLK_HZ / BIT_RATE_HZ;
  localparam int unsigned BIT_DIV_MAX_CYC = CLK_HZ / BIT_RATE_MIN_HZ;
  localparam int unsigned DIV_W           = 12;

  localparam int unsigned HIST_MAX_LEN    = 4;
  localparam int unsigned HIST_SHORT_LEN  = 3;

  localparam logic [HIST_MAX_LEN-1:0] HIST_RST = 4'h0;
  localparam logic [DIV_W-1:0]        DIV_RST  = 12'h000;
  localparam logic [DIV_W-1:0]        DIV_LAST = DIV_W'(BIT_DIV_CYC - 1);

endpackage : cvsdc_pkg

/* File: cvsdc_bitdiv.sv */
// Bit clock enable divider for the slope control logic.
// Assumes CLK_I is the 10 MHz system clock and RST_I is synchronous.
module cvsdc_bitdiv (
  input  wire logic CLK_I,
  input  wire logic RST_I,
  output logic      bit_en_o
);

  typedef struct packed {
    logic [cvsdc_pkg::DIV_W-1:0] cnt;
    logic                        en;
  } cvsdc_div_t;

  cvsdc_div_t st_r;
  cvsdc_div_t st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.en = 1'b0;
    if (st_r.cnt == cvsdc_pkg::DIV_LAST) begin
      st_nxt.cnt = cvsdc_pkg::DIV_RST;
      st_nxt.en  = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 12'h001;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      st_r <= '{cnt: cvsdc_pkg::DIV_RST, en: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bit_en_o = st_r.en;

endmodule // cvsdc_bitdiv

/* File: cvsdc_core.sv */
// Slope control logic of a delta modulation codec: sign latch, history
// register and coincidence detector, run per bit clock enable on transmit and per RX_BIT_VALID_I on receive.
// Assumes the comparator sign arrives asynchronously and the analog
// integrator, syllabic filter and current converter sit outside.
//
// What this block does
// - Latch comparator sign each bit clock, output serially.
// - Sign bit is both data and ramp direction.
// - History register is three or four bits.
// - Coincidence when history all ones or zeros.
// - Coincidence drives syllabic filter; sign sets polarity.
// - Idle input gives alternating bits, no coincidence.
// - Stream carries no framing or sync bits.
// - Bit clock at least 8 kHz.
// - Bit rate equals sample rate, 16-32 kHz typical.
module cvsdc_core (
  input  wire logic CLK_I,
  input  wire logic RST_I,
  input  wire logic CMP_SIGN_I,
  input  wire logic LEN4_SEL_I,
  input  wire logic RX_BIT_I,
  input  wire logic RX_BIT_VALID_I,
  output logic      BIT_EN_O,
  output logic      TX_BIT_O,
  output logic      RAMP_UP_O,
  output logic      COINC_O,
  output logic      RX_RAMP_UP_O,
  output logic      RX_COINC_O
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0]                         sync;
    logic                               len4;
    logic [cvsdc_pkg::HIST_MAX_LEN-1:0] tx_hist;
    logic                               tx_bit;
    logic                               tx_coinc;
    logic [cvsdc_pkg::HIST_MAX_LEN-1:0] rx_hist;
    logic                               rx_bit;
    logic                               rx_coinc;
  } cvsdc_st_t;

  cvsdc_st_t st_r;
  cvsdc_st_t st_nxt;
  logic      bit_en;

  ////////////////////////////////////////////////////////////////////////////
  cvsdc_bitdiv u_bitdiv (
    .CLK_I    (CLK_I),
    .RST_I    (RST_I),
    .bit_en_o (bit_en)
  );

  // All ones or all zeros over the selected length; the fourth stage is
  // ignored for the short option.
  function automatic logic coinc_of(input logic [3:0] h, input logic len4);
    logic lo3;
    lo3 = (h[2:0] == 3'h7) || (h[2:0] == 3'h0);
    if (len4) begin
      coinc_of = (h == 4'hf) || (h == 4'h0);
    end else begin
      coinc_of = lo3;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [3:0] th;
    logic [3:0] rh;
    th     = {st_r.tx_hist[2:0], st_r.sync[1]};
    rh     = {st_r.rx_hist[2:0], RX_BIT_I};
    st_nxt = st_r;
    // Length option is a static strap, captured each clock after reset.
    st_nxt.len4 = LEN4_SEL_I;
    // The comparator is asynchronous, so it is resynchronised before use.
    st_nxt.sync = {st_r.sync[0], CMP_SIGN_I};
    if (bit_en) begin
      // Latched sign becomes the transmitted bit, no framing added.
      st_nxt.tx_bit   = st_r.sync[1];
      st_nxt.tx_hist  = th;
      // Shifted value includes the new bit, so an idle alternating input
      // raises no coincidence once its own bits fill the stages in use.
      st_nxt.tx_coinc = coinc_of(th, st_r.len4);
    end
    // The receive path needs no reset to resynchronise: it only ever
    // looks at the last few bits, so stale contents flush out.
    if (RX_BIT_VALID_I) begin
      st_nxt.rx_bit   = RX_BIT_I;
      st_nxt.rx_hist  = rh;
      st_nxt.rx_coinc = coinc_of(rh, st_r.len4);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      st_r.sync     <= 2'h0;
      st_r.len4     <= 1'b0;
      st_r.tx_hist  <= cvsdc_pkg::HIST_RST;
      st_r.tx_bit   <= 1'b0;
      st_r.tx_coinc <= 1'b0;
      st_r.rx_hist  <= cvsdc_pkg::HIST_RST;
      st_r.rx_bit   <= 1'b0;
      st_r.rx_coinc <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign BIT_EN_O     = bit_en;
  assign TX_BIT_O     = st_r.tx_bit;
  assign RAMP_UP_O    = st_r.tx_bit;
  assign COINC_O      = st_r.tx_coinc;
  assign RX_RAMP_UP_O = st_r.rx_bit;
  assign RX_COINC_O   = st_r.rx_coinc;

endmodule // cvsdc_core

/* File: cvsdc_chk.sv */
// Port checker for cvsdc_core; sees only the top module's ports.
// Assumes it is bound into cvsdc_core and shares its clock and reset.
module cvsdc_chk (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic CMP_SIGN_I,
  input wire logic LEN4_SEL_I,
  input wire logic RX_BIT_I,
  input wire logic RX_BIT_VALID_I,
  input wire logic BIT_EN_O,
  input wire logic TX_BIT_O,
  input wire logic RAMP_UP_O,
  input wire logic COINC_O,
  input wire logic RX_RAMP_UP_O,
  input wire logic RX_COINC_O
);
  logic [3:0] h_r, r_r;
  function automatic logic co(logic [3:0] w, logic l);
    return l ? (&w | ~|w) : (&w[2:0] | ~|w[2:0]);
  endfunction
  always_ff @(posedge CLK_I) begin
    h_r <= RST_I ? 4'h0 : ($past(BIT_EN_O) ? {h_r[2:0], TX_BIT_O} : h_r);
    r_r <= RST_I ? 4'h0 : (RX_BIT_VALID_I ? {r_r[2:0], RX_BIT_I} : r_r);
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  a_tx_hold: assert property (!BIT_EN_O |=> $stable(TX_BIT_O)) else $error("tx");
  a_tx_sample: assert property (BIT_EN_O |=> TX_BIT_O == $past(CMP_SIGN_I, 3))
    else $error("sample");
  a_ramp_sign: assert property (RAMP_UP_O == TX_BIT_O) else $error("ramp");
  a_en_period: assert property (BIT_EN_O |-> ##[625:625] BIT_EN_O) else $error("en");
  a_en_pulse: assert property (BIT_EN_O |=> !BIT_EN_O[*8]) else $error("pulse");
  a_coinc_hist: assert property ($past(BIT_EN_O) |->
    COINC_O == co({h_r[2:0], TX_BIT_O}, LEN4_SEL_I)) else $error("coinc");
  a_coinc_hold: assert property (!BIT_EN_O |=> $stable(COINC_O)) else $error("hold");
  a_rx_bit: assert property (RX_BIT_VALID_I |=> RX_RAMP_UP_O == $past(RX_BIT_I))
    else $error("rx");
  a_rx_coinc: assert property (RX_BIT_VALID_I |=> RX_COINC_O == co(r_r, LEN4_SEL_I))
    else $error("rxc");
endmodule // cvsdc_chk
bind cvsdc_core cvsdc_chk u_chk (.*);

/* File: cvsdc_far_end.sv */
// Far end: loops the unframed stream back; never reset.
// Assumes it runs on the core's clock and sees its bit enable and output.
module cvsdc_far_end (
  input  wire logic CLK_I,
  input  wire logic bit_en_i,
  input  wire logic tx_bit_i,
  output logic      rx_bit_o = 1'b0,
  output logic      rx_valid_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic en_d = 1'b0;
  always @(posedge CLK_I) begin
    en_d <= bit_en_i;
    rx_valid_o <= en_d;
    rx_bit_o <= en_d ? tx_bit_i : ~rx_bit_o;
  end
endmodule // cvsdc_far_end

/* File: cvsd_slope_control_logic_tb_top.sv */
// Bench for cvsdc_core; the far end echoes the stream into the rx port.
module cvsd_slope_control_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK_I = 1'b0, RST_I = 1'b1, CMP_SIGN_I = 1'b0, LEN4_SEL_I = 1'b0;
  logic RX_BIT_I, RX_BIT_VALID_I, BIT_EN_O, TX_BIT_O, RAMP_UP_O, COINC_O;
  logic RX_RAMP_UP_O, RX_COINC_O;
  int n_errors = 0, check_count = 0;
  int q[$] = '{0, 0, 0, 0};
  always #50 CLK_I = ~CLK_I;
  cvsdc_core uut (.*);
  cvsdc_far_end far (.CLK_I(CLK_I), .bit_en_i(BIT_EN_O), .tx_bit_i(TX_BIT_O),
    .rx_bit_o(RX_BIT_I),
    .rx_valid_o(RX_BIT_VALID_I));
  task automatic chk(string nm, logic e, logic g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %b got %b", nm, e, g);
    end
  endtask
  function automatic logic ec();
    int l = LEN4_SEL_I ? 4 : 3;
    int a = 0;
    for (int i = 1; i <= l; i++) a += q[q.size() - i];
    return a == 0 || a == l;
  endfunction
  task automatic step(logic s);
    int n = 0;
    @(posedge CLK_I) CMP_SIGN_I <= s;
    q.push_back(int'(s));
    while (BIT_EN_O !== 1'b1 && n < 700) begin
      @(negedge CLK_I);
      n++;
    end
    @(negedge CLK_I);
    chk("tx", s, TX_BIT_O);
    chk("ramp", s, RAMP_UP_O);
    chk("coinc", ec(), COINC_O);
    repeat (2) @(negedge CLK_I);
    chk("rx", s, RX_RAMP_UP_O);
    chk("rxc", ec(), RX_COINC_O);
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #6_000_000;
    n_errors++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'ha30b));
    repeat (20) @(posedge CLK_I);
    RST_I <= 1'b0;
    for (int i = 0; i < 8; i++) step(1'(i));
    repeat (4) step(1'b1);
    repeat (4) step(1'b0);
    @(posedge CLK_I) RST_I <= 1'b1;
    LEN4_SEL_I <= 1'b1;
    repeat (3) @(posedge CLK_I);
    RST_I <= 1'b0;
    q = '{0, 0, 0, 0};
    repeat (36) step(1'($urandom % 2));
    repeat (4) step(1'b1);
    print_verdict();
  end
endmodule // cvsd_slope_control_logic_tb_top
